/* File: hw/lfc_frame_checker.sv */
/*
 Receive-side frame checker: break, sync auto-baud, identifier parity,
 dual checksum, time-outs, one error code per frame, Avalon-MM registers.
 Assumes lin_rx_in is the raw bus level, asynchronous to clk_in.
*/
`timescale 1ns/1ps
module lfc_frame_checker #(
   parameter int unsigned CYC_PER_MS = lfc_pkg::MS_NS / lfc_pkg::CLK_NS
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic lin_rx_in,
   input wire logic [5:0] address_in,
   input wire logic read_in,
   input wire logic write_in,
   input wire logic [31:0] writedata_in,
   output logic [31:0] readdata_out,
   output logic waitrequest_out
);
   function automatic logic [7:0] addc(input logic [7:0] a, input logic [7:0] b);
      logic [8:0] t;
      t = {1'b0, a} + {1'b0, b};
      return t[7:0] + {7'h00, t[8]};
   endfunction

   lfc_pkg::lfc_cs_t cs_q, cs_d;
   lfc_pkg::lfc_ph_t ph_q, ph_d;
   logic rx1_q, rx2_q, rx3_q;
   logic [19:0] cnt_q, cnt_d;
   logic [3:0] nb_q, nb_d, n_q, n_d, err_q, err_d;
   logic [7:0] sh_q, sh_d, sum_q, sum_d, prv_q, prv_d, lst_q, lst_d, pid_q, pid_d;
   logic [2:0] edg_q, edg_d;
   logic [15:0] bit_q, bit_d, tout_q, tout_d, div_q, div_d, rbit_q, rbit_d;
   logic [71:0] buf_q, buf_d;
   logic [31:0] tmr_q, tmr_d, pre_q, pre_d, ms_q, ms_d;
   logic [31:0] info_q, info_d, ts_q, ts_d, rdata_q, rdata_d;
   logic [63:0] data_q, data_d;
   logic [7:0] chk_q, chk_d;
   logic end_q, end_d, rdy_q, rdy_d, wait_q, wait_d;
   logic [15:0] bt, meas;
   logic [47:0] lim;
   logic fall, tmo, wr, clr_ts;
   logic id_parity_low, id_parity_high_inverted;
   logic [7:0] cls, enh;
   logic [1:0] checksum_kind_report;
   logic [3:0] code;

   assign readdata_out = rdata_q;
   assign waitrequest_out = wait_q;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         rx1_q <= 1'b1;
         rx2_q <= 1'b1;
         rx3_q <= 1'b1;
      end else begin
         rx1_q <= lin_rx_in;
         rx2_q <= rx1_q;
         rx3_q <= rx2_q;
      end
   end

   // Master rate while hunting for a break; measured rate from the sync field to frame end
   assign bt = (ph_q == lfc_pkg::PH_HUNT) ? div_q : bit_q;
   assign fall = rx3_q & ~rx2_q;
   assign meas = cnt_q[18:3];
   assign lim = (tout_q == 16'h0000) ? {32'h0, bt} * {40'h0, lfc_pkg::TOUT_BITS}
      : {32'h0, tout_q} * 48'(CYC_PER_MS);
   assign tmo = (ph_q == lfc_pkg::PH_RESP) && ({16'h0, tmr_q} >= lim);
   assign id_parity_low = sh_q[0] ^ sh_q[1] ^ sh_q[2] ^ sh_q[4];
   assign id_parity_high_inverted = ~(sh_q[1] ^ sh_q[3] ^ sh_q[4] ^ sh_q[5]);
   assign cls = prv_q;
   assign enh = addc(prv_q, pid_q);

   always_comb begin
      if (n_q == 4'h0) begin
         checksum_kind_report = lfc_pkg::K_NONE;
      end else if (~cls == lst_q) begin
         checksum_kind_report = lfc_pkg::K_CLS;
      end else if (~enh == lst_q) begin
         checksum_kind_report = lfc_pkg::K_ENH;
      end else begin
         checksum_kind_report = lfc_pkg::K_ERR;
      end
      // First error found wins
      if (err_q != lfc_pkg::E_NONE) begin
         code = err_q;
      end else if (checksum_kind_report == lfc_pkg::K_ERR) begin
         code = lfc_pkg::E_CSUM;
      end else begin
         code = lfc_pkg::E_NONE;
      end
   end

   always_comb begin
      cs_d = cs_q;
      ph_d = ph_q;
      cnt_d = cnt_q + 20'h1;
      nb_d = nb_q;
      sh_d = sh_q;
      edg_d = edg_q;
      bit_d = bit_q;
      n_d = n_q;
      buf_d = buf_q;
      sum_d = sum_q;
      prv_d = prv_q;
      lst_d = lst_q;
      pid_d = pid_q;
      err_d = err_q;
      end_d = 1'b0;
      tmr_d = (ph_q == lfc_pkg::PH_RESP) ? tmr_q + 32'h1 : 32'h0;
      case (cs_q)
         lfc_pkg::S_IDLE: begin
            if (fall) begin
               cs_d = lfc_pkg::S_START;
               cnt_d = 20'h0;
            end
         end
         lfc_pkg::S_START: begin
            if (cnt_q == {5'h00, bt[15:1]}) begin
               cs_d = rx2_q ? lfc_pkg::S_IDLE : lfc_pkg::S_BITS;
               cnt_d = 20'h0;
               nb_d = 4'h0;
            end
         end
         lfc_pkg::S_BITS: begin
            if (cnt_q == {4'h0, bt} - 20'h1) begin
               sh_d = {rx2_q, sh_q[7:1]};
               cnt_d = 20'h0;
               nb_d = nb_q + 4'h1;
               if (nb_q == lfc_pkg::NBITS - 4'h1) begin
                  cs_d = lfc_pkg::S_STOP;
               end
            end
         end
         lfc_pkg::S_STOP: begin
            if (cnt_q == {4'h0, bt} - 20'h1) begin
               cs_d = lfc_pkg::S_IDLE;
               if (sh_q == 8'h00 && !rx2_q) begin
                  cs_d = lfc_pkg::S_BRKHI;
                  ph_d = lfc_pkg::PH_SYNC;
                  end_d = (ph_q == lfc_pkg::PH_RESP);
               end else if (ph_q == lfc_pkg::PH_HUNT) begin
                  if (sh_q == 8'h00) begin
                     cs_d = lfc_pkg::S_SYNC;
                     ph_d = lfc_pkg::PH_SYNC;
                     edg_d = 3'h0;
                     err_d = lfc_pkg::E_ASSUMED_BREAK_ERROR;
                  end else begin
                     err_d = lfc_pkg::E_BRK;
                     end_d = 1'b1;
                  end
               end else if (ph_q == lfc_pkg::PH_ID) begin
                  pid_d = sh_q;
                  ph_d = lfc_pkg::PH_RESP;
                  if (err_q == lfc_pkg::E_NONE) begin
                     if (!rx2_q) begin
                        err_d = lfc_pkg::E_FRM;
                     end else if (sh_q[7:6] != {id_parity_high_inverted, id_parity_low}) begin
                        err_d = lfc_pkg::E_PAR;
                     end
                  end
               end else if (ph_q == lfc_pkg::PH_RESP) begin
                  // Checksum byte kept apart from data byte 0
                  if (n_q == lfc_pkg::LAST_BYTE) begin
                     buf_d[71:64] = sh_q;
                     end_d = 1'b1;
                     ph_d = lfc_pkg::PH_HUNT;
                  end else begin
                     buf_d[{n_q[2:0], 3'h0} +: 8] = sh_q;
                  end
                  prv_d = sum_q;
                  sum_d = addc(sum_q, sh_q);
                  lst_d = sh_q;
                  n_d = n_q + 4'h1;
                  if (!rx2_q && err_q == lfc_pkg::E_NONE) begin
                     err_d = lfc_pkg::E_FRM;
                  end
               end
            end
         end
         lfc_pkg::S_BRKHI: begin
            if (rx2_q) begin
               cs_d = lfc_pkg::S_SYNC;
               edg_d = 3'h0;
            end
         end
         lfc_pkg::S_SYNC: begin
            if (fall) begin
               edg_d = edg_q + 3'h1;
               // Edge cycle counted, so the fifth edge sees eight full bits
               if (edg_q == 3'h0) begin
                  cnt_d = 20'h1;
               end
               if (edg_q == lfc_pkg::SYNC_LAST) begin
                  bit_d = meas;
                  ph_d = lfc_pkg::PH_ID;
                  cs_d = lfc_pkg::S_IDLE;
               end
            end
         end
         default: cs_d = lfc_pkg::S_IDLE;
      endcase
      if (tmo) begin
         ph_d = lfc_pkg::PH_HUNT;
         cs_d = lfc_pkg::S_IDLE;
         end_d = 1'b1;
         if (err_q == lfc_pkg::E_NONE) begin
            if (cs_q != lfc_pkg::S_IDLE) begin
               err_d = lfc_pkg::E_BUSTO;
            end else if (n_q == 4'h0) begin
               err_d = lfc_pkg::E_NOANS;
            end
         end
      end
      // Frame state cleared once the report is latched
      if (end_q) begin
         n_d = 4'h0;
         sum_d = 8'h00;
         prv_d = 8'h00;
         err_d = lfc_pkg::E_NONE;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         cs_q <= lfc_pkg::S_IDLE;
         ph_q <= lfc_pkg::PH_HUNT;
         cnt_q <= 20'h0;
         nb_q <= 4'h0;
         sh_q <= 8'h00;
         edg_q <= 3'h0;
         bit_q <= lfc_pkg::DIV_RST;
         n_q <= 4'h0;
         buf_q <= 72'h0;
         sum_q <= 8'h00;
         prv_q <= 8'h00;
         lst_q <= 8'h00;
         pid_q <= 8'h00;
         err_q <= lfc_pkg::E_NONE;
         end_q <= 1'b0;
         tmr_q <= 32'h0;
      end else begin
         cs_q <= cs_d;
         ph_q <= ph_d;
         cnt_q <= cnt_d;
         nb_q <= nb_d;
         sh_q <= sh_d;
         edg_q <= edg_d;
         bit_q <= bit_d;
         n_q <= n_d;
         buf_q <= buf_d;
         sum_q <= sum_d;
         prv_q <= prv_d;
         lst_q <= lst_d;
         pid_q <= pid_d;
         err_q <= err_d;
         end_q <= end_d;
         tmr_q <= tmr_d;
      end
   end

   assign wr = write_in & ~wait_q;
   assign clr_ts = wr && address_in == lfc_pkg::A_CTRL && writedata_in[lfc_pkg::C_TSCLR];

   always_comb begin
      info_d = info_q;
      chk_d = chk_q;
      rbit_d = rbit_q;
      ts_d = ts_q;
      data_d = data_q;
      rdy_d = rdy_q & ~(wr && address_in == lfc_pkg::A_CTRL
         && writedata_in[lfc_pkg::C_RDYCLR]);
      pre_d = pre_q + 32'h1;
      ms_d = ms_q;
      if (pre_q == 32'(CYC_PER_MS - 1)) begin
         pre_d = 32'h0;
         ms_d = ms_q + 32'h1;
      end
      if (end_q) begin
         info_d = 32'h0;
         info_d[lfc_pkg::F_ID +: 8] = pid_q;
         info_d[lfc_pkg::F_N +: 4] = (n_q == 4'h0) ? 4'h0 : n_q - 4'h1;
         info_d[lfc_pkg::F_KIND +: 2] = checksum_kind_report;
         info_d[lfc_pkg::F_ERR +: 4] = code;
         chk_d = lst_q;
         rbit_d = bit_q;
         ts_d = ms_q;
         data_d = buf_q[63:0];
         rdy_d = 1'b1;
      end
      if (end_q || clr_ts) begin
         pre_d = 32'h0;
         ms_d = 32'h0;
      end
   end

   always_comb begin
      wait_d = 1'b1;
      rdata_d = rdata_q;
      tout_d = tout_q;
      div_d = div_q;
      if ((read_in || write_in) && wait_q) begin
         wait_d = 1'b0;
         case (address_in)
            lfc_pkg::A_TOUT: rdata_d = {16'h0, tout_q};
            lfc_pkg::A_DIV: rdata_d = {16'h0, div_q};
            lfc_pkg::A_STAT: rdata_d = {24'h0, ph_q, 3'h0, rdy_q};
            lfc_pkg::A_INFO: rdata_d = info_q;
            lfc_pkg::A_CHK: rdata_d = {24'h0, chk_q};
            lfc_pkg::A_BIT: rdata_d = {16'h0, rbit_q};
            lfc_pkg::A_TS: rdata_d = ts_q;
            lfc_pkg::A_DLO: rdata_d = data_q[31:0];
            lfc_pkg::A_DHI: rdata_d = data_q[63:32];
            default: rdata_d = 32'h0;
         endcase
      end
      if (wr && address_in == lfc_pkg::A_TOUT) begin
         tout_d = writedata_in[15:0];
      end
      if (wr && address_in == lfc_pkg::A_DIV) begin
         div_d = writedata_in[15:0];
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         info_q <= 32'h0;
         chk_q <= 8'h00;
         rbit_q <= 16'h0000;
         ts_q <= 32'h0;
         data_q <= 64'h0;
         rdy_q <= 1'b0;
         pre_q <= 32'h0;
         ms_q <= 32'h0;
         wait_q <= 1'b1;
         rdata_q <= 32'h0;
         tout_q <= lfc_pkg::TOUT_RST;
         div_q <= lfc_pkg::DIV_RST;
      end else begin
         info_q <= info_d;
         chk_q <= chk_d;
         rbit_q <= rbit_d;
         ts_q <= ts_d;
         data_q <= data_d;
         rdy_q <= rdy_d;
         pre_q <= pre_d;
         ms_q <= ms_d;
         wait_q <= wait_d;
         rdata_q <= rdata_d;
         tout_q <= tout_d;
         div_q <= div_d;
      end
   end

   sequence s_rep;
      end_q ##1 rdy_q;
   endsequence
   property p_report;
      @(posedge clk_in) disable iff (rst_in)
         end_q |=> rdy_q && info_q[7:0] == $past(pid_q)
         && info_q[13:12] == $past(checksum_kind_report);
   endproperty
   a_report: assert property (p_report) else $error("report not latched");
   property p_kind_err;
      @(posedge clk_in) disable iff (rst_in)
         end_q && n_q != 4'h0 && ~prv_q != lst_q && ~enh != lst_q
         |=> info_q[13:12] == lfc_pkg::K_ERR;
   endproperty
   a_kind_err: assert property (p_kind_err) else $error("kind not error");
   property p_one_err;
      @(posedge clk_in) disable iff (rst_in)
         end_q && err_q != lfc_pkg::E_NONE |=> info_q[19:16] == $past(err_q);
   endproperty
   a_one_err: assert property (p_one_err) else $error("wrong error code");
   property p_parity;
      @(posedge clk_in) disable iff (rst_in)
         cs_q == lfc_pkg::S_STOP && cs_d == lfc_pkg::S_IDLE && ph_q == lfc_pkg::PH_ID
         && err_q == lfc_pkg::E_NONE && rx2_q
         && sh_q[7:6] != {id_parity_high_inverted, id_parity_low}
         |=> err_q == lfc_pkg::E_PAR;
   endproperty
   a_parity: assert property (p_parity) else $error("parity error missed");
   property p_timeout;
      @(posedge clk_in) disable iff (rst_in) tmo |=> s_rep;
   endproperty
   a_timeout: assert property (p_timeout) else $error("time-out not reported");
   property p_noans;
      @(posedge clk_in) disable iff (rst_in)
         tmo && n_q == 4'h0 && cs_q == lfc_pkg::S_IDLE && err_q == lfc_pkg::E_NONE
         |=> ##1 info_q[19:16] == lfc_pkg::E_NOANS;
   endproperty
   a_noans: assert property (p_noans) else $error("no-answer missed");
   property p_autobaud;
      @(posedge clk_in) disable iff (rst_in)
         cs_q == lfc_pkg::S_SYNC && fall && edg_q == lfc_pkg::SYNC_LAST
         |=> bit_q == $past(meas) && ph_q == lfc_pkg::PH_ID;
   endproperty
   a_autobaud: assert property (p_autobaud) else $error("rate not measured");
   property p_stamp;
      @(posedge clk_in) disable iff (rst_in) end_q |=> ms_q == 32'h0 && ts_q == $past(ms_q);
   endproperty
   a_stamp: assert property (p_stamp) else $error("time stamp wrong");
endmodule

/* File: hw/lfc_pkg.sv */
/*
 Constants, field layouts and state types for the frame checker.
 Assumes a 100 MHz clock and a word-aligned Avalon-MM slave.
*/
// Behaviour
// - Classic checksum covers only the data bytes of a frame.
// - Checksum adds eight bits with end-around carry (subtract 255 at 256+).
// - Enhanced checksum covers data bytes plus the protected identifier.
// - Every frame with a response byte gets both checksums compared; the matching form is reported.
// - Neither matching reports the checksum kind as error.
// - Bit rate is measured over each frame's sync field and reported.
// - Only one error code is reported per frame.
// - Identifier carries parity in bit 6 and inverted parity in bit 7.
// - Checksum error when covered sum plus checksum is not all ones.
// - Header seen but no response byte begun before time-out gives no-answer error.
// - Bus time-out after the eight-byte frame time, about 140 percent scaled.
// - Time-out programmable in ms; zero selects the bit-time based time-out.
// - Bit rate for originated traffic comes from a configurable setting.
// - Transmit read-back compare is optional and not done by this monitor.
// - Framing error when the stop bit is dominant; break exempt.
// - Data before a valid break gives a break error.
// - First byte 0x00 without framing error is taken as an assumed break.
// - Each frame carries time since the previous frame; clear resets it.
// - A frame carries zero to eight data bytes, then the checksum.
package lfc_pkg;
   localparam int CLK_NS = 10;
   localparam int MS_NS = 1000000;
   localparam logic [5:0] A_CTRL = 6'h00;
   localparam logic [5:0] A_TOUT = 6'h04;
   localparam logic [5:0] A_DIV = 6'h08;
   localparam logic [5:0] A_STAT = 6'h0C;
   localparam logic [5:0] A_INFO = 6'h10;
   localparam logic [5:0] A_CHK = 6'h14;
   localparam logic [5:0] A_BIT = 6'h18;
   localparam logic [5:0] A_TS = 6'h1C;
   localparam logic [5:0] A_DLO = 6'h20;
   localparam logic [5:0] A_DHI = 6'h24;
   localparam int C_TSCLR = 0;
   localparam int C_RDYCLR = 1;
   localparam int F_ID = 0;
   localparam int F_N = 8;
   localparam int F_KIND = 12;
   localparam int F_ERR = 16;
   localparam logic [15:0] TOUT_RST = 16'h0000;
   localparam logic [15:0] DIV_RST = 16'h28B1;
   // 124 bit longest frame times 1.4
   localparam logic [7:0] TOUT_BITS = 8'hAE;
   localparam logic [2:0] SYNC_LAST = 3'h4;
   localparam logic [3:0] NBITS = 4'h8;
   localparam logic [3:0] LAST_BYTE = 4'h8;
   localparam logic [1:0] K_NONE = 2'h0;
   localparam logic [1:0] K_CLS = 2'h1;
   localparam logic [1:0] K_ENH = 2'h2;
   localparam logic [1:0] K_ERR = 2'h3;
   localparam logic [3:0] E_NONE = 4'h0;
   localparam logic [3:0] E_PAR = 4'h1;
   localparam logic [3:0] E_CSUM = 4'h2;
   localparam logic [3:0] E_FRM = 4'h3;
   localparam logic [3:0] E_NOANS = 4'h4;
   localparam logic [3:0] E_BRK = 4'h5;
   localparam logic [3:0] E_BUSTO = 4'h6;
   localparam logic [3:0] E_ASSUMED_BREAK_ERROR = 4'h7;
   typedef enum logic [5:0] {S_IDLE = 6'h01, S_START = 6'h02, S_BITS = 6'h04,
      S_STOP = 6'h08, S_BRKHI = 6'h10, S_SYNC = 6'h20} lfc_cs_t;
   typedef enum logic [3:0] {PH_HUNT = 4'h1, PH_SYNC = 4'h2, PH_ID = 4'h4,
      PH_RESP = 4'h8} lfc_ph_t;
endpackage

/* File: verification/lfc_lin_node.sv */
/*
 Bus node model that drives the checker's receive pin with frames.
 Assumes the bench sets bt, leaves div at 16, and calls the tasks just after a
 rising edge of clk_in; the line idles recessive.
*/
`timescale 1ns/1ps
module lfc_lin_node (
   input wire logic clk_in,
   output logic lin_out
);
   int bt = 16;
   int div = 16;
   initial lin_out = 1'b1;
   task automatic hold(input logic v, input int n);
      lin_out <= v;
      repeat (n) @(posedge clk_in);
   endtask
   // One character, LSB first; dominant stop only when asked
   task automatic send_byte(input logic [7:0] b, input logic stop);
      hold(1'b0, bt);
      for (int i = 0; i < 8; i++) begin
         hold(b[i], bt);
      end
      hold(stop, bt);
      if (!stop) begin
         hold(1'b1, bt);
      end
   endtask
   // Break at divider rate, or a plain 0x00 character instead
   task automatic send_header(input logic brk, input logic [7:0] pid);
      if (brk) begin
         hold(1'b0, 13 * div);
         hold(1'b1, div);
      end else begin
         send_byte(8'h00, 1'b1);
      end
      send_byte(8'h55, 1'b1);
      send_byte(pid, 1'b1);
   endtask
   task automatic send_frame(input logic brk, input logic [7:0] pid, input int n,
         input logic [63:0] d, input logic [7:0] chk, input int bad);
      send_header(brk, pid);
      for (int i = 0; i < n; i++) begin
         send_byte(d[i*8+:8], i != bad);
      end
      send_byte(chk, 1'b1);
   endtask
endmodule

/* File: verification/lfc_tb.sv */
/*
 Self-checking bench for the frame checker: Avalon-MM register access,
 frames from the node model, one report per frame.
 Assumes the design package and the node model are compiled first.
*/
`timescale 1ns/1ps
module testbench;
   typedef struct {
      logic [5:0] id;
      logic pbad;
      int n;
      logic [63:0] data;
      logic [1:0] mode;
      int bt;
      logic [1:0] kind;
      logic [3:0] err;
   } lfc_row_t;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   wire lin_rx;
   logic [5:0] address_in = 6'h00;
   logic read_in = 1'b0;
   logic write_in = 1'b0;
   logic [31:0] writedata_in = 32'h00000000;
   logic [31:0] readdata_out;
   logic waitrequest_out;
   logic [31:0] q;
   int fail_count = 0;
   int n_tests = 0;
   int cyc = 0;
   int t0;
   logic [5:0] ra[6] = '{lfc_pkg::A_TOUT, lfc_pkg::A_DIV, lfc_pkg::A_BIT,
      lfc_pkg::A_STAT, lfc_pkg::A_CTRL, 6'h3C};
   logic [31:0] rv[6] = '{32'h0, 32'h28B1, 32'h0, 32'h10, 32'h0, 32'h0};
   // Mode 0 classic, 1 enhanced, 2 corrupted checksum
   lfc_row_t rows[8] = '{
      '{6'h3C, 1'b0, 8, 64'h0, 2'h0, 16, 2'h1, 4'h0},
      '{6'h20, 1'b0, 4, 64'h44332200, 2'h0, 16, 2'h1, 4'h0},
      '{6'h11, 1'b0, 2, 64'hFFFF, 2'h1, 16, 2'h2, 4'h0},
      '{6'h05, 1'b0, 0, 64'h0, 2'h0, 16, 2'h1, 4'h0},
      '{6'h2A, 1'b0, 3, 64'h0A0B0C, 2'h2, 16, 2'h3, 4'h2},
      '{6'h15, 1'b1, 2, 64'h1234, 2'h0, 16, 2'h1, 4'h1},
      '{6'h07, 1'b1, 1, 64'h99, 2'h2, 16, 2'h3, 4'h1},
      '{6'h3F, 1'b0, 8, 64'hF0E0D0C0B0A09080, 2'h1, 24, 2'h2, 4'h0}};
   lfc_frame_checker #(.CYC_PER_MS(10)) uut (.clk_in(clk_in), .rst_in(rst_in),
      .lin_rx_in(lin_rx), .address_in(address_in), .read_in(read_in),
      .write_in(write_in), .writedata_in(writedata_in),
      .readdata_out(readdata_out), .waitrequest_out(waitrequest_out));
   lfc_lin_node node (.clk_in(clk_in), .lin_out(lin_rx));
   initial begin
      forever #5 clk_in = ~clk_in;
   end
   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         fail_count++;
         finish_test();
      end
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Holds the request until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
      address_in <= a;
      writedata_in <= d;
      read_in <= !wr;
      write_in <= wr;
      @(posedge clk_in);
      while (waitrequest_out !== 1'b0) begin
         @(posedge clk_in);
      end
      q = readdata_out;
      read_in <= 1'b0;
      write_in <= 1'b0;
      @(posedge clk_in);
   endtask
   task automatic wait_ready();
      q = 32'h0;
      while (q[0] !== 1'b1) begin
         bus(1'b0, lfc_pkg::A_STAT, 32'h0);
      end
   endtask
   function automatic logic [7:0] pid(input logic [5:0] id, input logic bad);
      return {~(id[1] ^ id[3] ^ id[4] ^ id[5]) ^ bad,
         id[0] ^ id[1] ^ id[2] ^ id[4], id};
   endfunction
   function automatic logic [7:0] csum(input logic [7:0] p, input int n,
         input logic [63:0] d);
      int s;
      s = p;
      for (int i = 0; i < n; i++) begin
         s = s + d[i*8+:8];
         if (s >= 256) begin
            s = s - 255;
         end
      end
      return ~s[7:0];
   endfunction
   task automatic run_row(input lfc_row_t r, input logic brk, input int bad);
      logic [7:0] p;
      logic [7:0] c;
      logic [31:0] m;
      logic [31:0] mh;
      p = pid(r.id, r.pbad);
      c = csum(r.mode == 2'h1 ? p : 8'h00, r.n, r.data);
      if (r.mode == 2'h2) begin
         c = c ^ 8'h01;
      end
      m = r.n >= 4 ? 32'hFFFFFFFF : (32'h1 << (8 * r.n)) - 32'h1;
      mh = r.n >= 8 ? 32'hFFFFFFFF : r.n > 4 ? (32'h1 << (8 * (r.n - 4))) - 32'h1 : 32'h0;
      node.bt = r.bt;
      bus(1'b1, lfc_pkg::A_CTRL, 32'h2);
      node.send_frame(brk, p, r.n, r.data, c, bad);
      wait_ready();
      bus(1'b0, lfc_pkg::A_INFO, 32'h0);
      chk("info", q & 32'h000F3FFF, {12'h0, r.err, 2'h0, r.kind, 4'(r.n), p});
      bus(1'b0, lfc_pkg::A_BIT, 32'h0);
      chk("bit time", q, 32'(r.bt));
      bus(1'b0, lfc_pkg::A_CHK, 32'h0);
      chk("checksum byte", q, {24'h0, c});
      bus(1'b0, lfc_pkg::A_DLO, 32'h0);
      chk("data", q & m, r.data[31:0] & m);
      bus(1'b0, lfc_pkg::A_DHI, 32'h0);
      chk("data high", q & mh, r.data[63:32] & mh);
   endtask
   initial begin
      repeat (6) @(posedge clk_in);
      rst_in <= 1'b0;
      @(posedge clk_in);
      for (int i = 0; i < 6; i++) begin
         bus(1'b0, ra[i], 32'h0);
         chk("reset value", q, rv[i]);
      end
      bus(1'b1, lfc_pkg::A_DIV, 32'h10);
      bus(1'b0, lfc_pkg::A_DIV, 32'h0);
      chk("divider", q, 32'h10);
      foreach (rows[i]) begin
         run_row(rows[i], 1'b1, 99);
      end
      run_row(lfc_row_t'{6'h12, 1'b0, 2, 64'h5533, 2'h0, 16, 2'h1, 4'h3}, 1'b1, 0);
      run_row(lfc_row_t'{6'h12, 1'b0, 1, 64'h77, 2'h0, 16, 2'h1, 4'h7}, 1'b0, 99);
      // Stamp cleared with ready; report lands about 158 cycles later
      bus(1'b1, lfc_pkg::A_CTRL, 32'h3);
      node.send_byte(8'h5A, 1'b1);
      wait_ready();
      bus(1'b0, lfc_pkg::A_INFO, 32'h0);
      chk("break error", q & 32'h000F0000, 32'h00050000);
      bus(1'b0, lfc_pkg::A_TS, 32'h0);
      chk("time stamp", 32'(q >= 32'hE && q <= 32'h11), 32'h1);
      // Short fixed time-out: header with no answer
      bus(1'b1, lfc_pkg::A_TOUT, 32'h3);
      bus(1'b0, lfc_pkg::A_TOUT, 32'h0);
      chk("time-out", q, 32'h3);
      bus(1'b1, lfc_pkg::A_CTRL, 32'h2);
      node.send_header(1'b1, pid(6'h12, 1'b0));
      t0 = cyc;
      wait_ready();
      chk("fixed time-out", 32'(cyc - t0 < 100), 32'h1);
      bus(1'b0, lfc_pkg::A_INFO, 32'h0);
      chk("no answer", q & 32'h000F0000, 32'h00040000);
      // Expiry in the middle of the second response byte
      bus(1'b1, lfc_pkg::A_TOUT, 32'h14);
      bus(1'b1, lfc_pkg::A_CTRL, 32'h2);
      node.send_header(1'b1, pid(6'h12, 1'b0));
      node.send_byte(8'h12, 1'b1);
      node.send_byte(8'hFF, 1'b1);
      wait_ready();
      bus(1'b0, lfc_pkg::A_INFO, 32'h0);
      chk("bus time-out", q & 32'h000F0000, 32'h00060000);
      rst_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      rst_in <= 1'b0;
      @(posedge clk_in);
      bus(1'b0, lfc_pkg::A_DIV, 32'h0);
      chk("divider after reset", q, 32'h28B1);
      bus(1'b0, lfc_pkg::A_TOUT, 32'h0);
      chk("time-out after reset", q, 32'h0);
      finish_test();
   end
endmodule
